// *** hdl/ovtl_limits.sv ***
`timescale 1ns/1ps
`include "ovtl_defines.svh"
module ovtl_limits import ovtl_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `OVTL_DEV_ADDR
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             alert_o,
  output logic             alert_oe,
  // Voltage control inputs
  input  wire logic [12:0] vout_command,
  input  wire logic        margin_high_sel,
  input  wire logic        conv_enable,
  input  wire logic [12:0] vout_min,
  input  wire logic [12:0] hw_max,
  input  wire logic [7:0]  trans_rate,
  // Nonvolatile restore and store
  input  wire logic        nvm_restore,
  input  wire logic        nvm_margin_dflt,
  input  wire logic [6:0]  nvm_trim,
  input  wire logic [11:0] nvm_vmax,
  input  wire logic        vmax_from_strap,
  input  wire logic [11:0] strap_vmax,
  output logic             margin_high_default_bit,
  // Status
  input  wire logic        status_clear,
  output logic             warn_max_min,
  output logic             status_byte_nota,
  output logic             status_word_vout,
  output logic             invalid_data,
  // Output target
  output logic      [12:0] vout_target,
  output logic      [12:0] vout_ramped,
  output logic             ramp_busy
);
  ovtl_main_s q;
  ovtl_main_s n;

  // Trim seen as a full sign-extended word
  function automatic logic [15:0] trim_word(input logic [6:0] t);
    trim_word = {{9{t[6]}}, t}; // R4
  endfunction

  // Margin code to step count in 1/64 units
  function automatic logic [3:0] mhi_step(input logic [10:0] c);
    logic [10:0] d;
    d = c - `OVTL_MHI_BASE;
    if (c < `OVTL_MHI_LO) begin
      mhi_step = `OVTL_MHI_MIN; // R19
    end else if (c >= `OVTL_MHI_SAT) begin
      mhi_step = `OVTL_MHI_MAX;
    end else begin
      mhi_step = d[6:3];
    end
  endfunction

  // Read data for a command code
  function automatic logic [15:0] reg_read(input logic [7:0] c,
                                           input ovtl_main_s s);
    case (c)
      `OVTL_CMD_TRIM: reg_read = trim_word(s.trim); // R4
      `OVTL_CMD_VMAX: reg_read = {4'h0, s.vmax}; // R8
      `OVTL_CMD_MHI:  reg_read = {5'h0, s.mhi}; // R16
      default:        reg_read = `OVTL_RD_NONE;
    endcase
  endfunction

  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [15:0] word;
  logic        commit;
  logic        bad;
  logic [16:0] prod;
  logic signed [15:0] raw;
  logic [12:0] hi_lim;
  logic [12:0] lo_lim;
  logic        gt_hi;
  logic        lt_lo;
  logic        clamp_act;
  logic [15:0] rd_word;

  // Pin edge and frame condition detection
  assign scl_rise = q.scl_s[1] & ~q.scl_d;
  assign scl_fall = ~q.scl_s[1] & q.scl_d;
  assign start_c  = q.scl_s[1] & q.scl_d & q.sda_d & ~q.sda_s[1];
  assign stop_c   = q.scl_s[1] & q.scl_d & ~q.sda_d & q.sda_s[1];

  // Word write completes at the high byte ack
  assign word   = {q.sh, q.lo};
  assign commit = (q.st == OVTL_RX) & scl_fall & (q.bitc == 4'h8)
                  & (q.bidx == 2'h3) & ~q.rd; // R1
  assign rd_word = reg_read(q.cmd, q);

  // Validity of written data per command
  always_comb begin
    case (q.cmd)
      `OVTL_CMD_TRIM: bad = (word[15:7] != {9{word[6]}}); // R7
      `OVTL_CMD_VMAX: bad = (word[15:12] != 4'h0); // R7 R8
      `OVTL_CMD_MHI:  bad = (word[15:11] != 5'h0); // R7 R16
      default:        bad = 1'b1;
    endcase
  end

  // Combined target: command, trim, scaled margin
  assign prod = 17'(vout_command) * 17'(mhi_step(q.mhi)); // R14 R19
  assign raw  = $signed({3'h0, vout_command}) + $signed(trim_word(q.trim))
              + (margin_high_sel ? $signed({5'h0, prod[16:`OVTL_MHI_SHIFT]})
                                 : 16'sh0); // R2 R14 R22

  // Ceiling is limit or hardware max; limit beats lower limit
  assign hi_lim = ({1'b0, q.vmax} < hw_max) ? {1'b0, q.vmax} : hw_max; // R6
  assign lo_lim = (vout_min > hi_lim) ? hi_lim : vout_min; // R12
  assign gt_hi  = raw > $signed({3'h0, hi_lim}); // R9 R20
  assign lt_lo  = raw < $signed({3'h0, lo_lim});
  assign clamp_act = gt_hi | lt_lo;

  // Bus slave, registers, target and status
  always_comb begin
    n = q;
    n.scl_s = {q.scl_s[0], scl_i};
    n.sda_s = {q.sda_s[0], sda_i};
    n.scl_d = q.scl_s[1];
    n.sda_d = q.sda_s[1];
    if (start_c) begin
      n.st = OVTL_RX;
      n.bitc = 4'h0;
      n.bidx = 2'h0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st = OVTL_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (q.st)
        OVTL_RX: begin
          if (scl_rise && q.bitc != 4'h8) begin
            n.sh = {q.sh[6:0], q.sda_s[1]};
            n.bitc = q.bitc + 4'h1;
          end else if (scl_fall && q.bitc == 4'h8) begin
            n.st = OVTL_RACK;
            n.sda_oe = 1'b1;
            case (q.bidx)
              2'h0: begin
                if (q.sh[7:1] == DEV_ADDR) begin
                  n.rd = q.sh[0];
                end else begin
                  n.st = OVTL_IDLE;
                  n.sda_oe = 1'b0;
                end
              end
              2'h1: n.cmd = q.sh;
              2'h2: n.lo = q.sh;
              default: n.lo = q.lo;
            endcase
          end
        end
        OVTL_RACK: begin
          if (scl_fall) begin
            n.bitc = 4'h0;
            if (q.bidx == 2'h0 && q.rd) begin
              n.st = OVTL_TX; // R1
              n.txd = rd_word;
              n.txhi = 1'b0;
              n.sh = rd_word[7:0];
              n.sda_oe = ~rd_word[7];
            end else begin
              n.st = (q.bidx == 2'h3 || q.rd) ? OVTL_IDLE : OVTL_RX;
              n.sda_oe = 1'b0;
              n.bidx = q.bidx + 2'h1;
            end
          end
        end
        OVTL_TX: begin
          if (scl_fall) begin
            n.bitc = q.bitc + 4'h1;
            n.sh = {q.sh[6:0], 1'b0};
            n.sda_oe = ~q.sh[6];
            if (q.bitc == 4'h7) begin
              n.st = OVTL_TACK;
              n.sda_oe = 1'b0;
            end
          end
        end
        OVTL_TACK: begin
          if (scl_rise) begin
            n.ack = ~q.sda_s[1] & ~q.txhi;
          end else if (scl_fall) begin
            n.bitc = 4'h0;
            if (q.ack) begin
              n.st = OVTL_TX;
              n.txhi = 1'b1;
              n.ack = 1'b0;
              n.sh = q.txd[15:8];
              n.sda_oe = ~q.txd[15];
            end else begin
              n.st = OVTL_IDLE;
            end
          end
        end
        default: n.st = OVTL_IDLE;
      endcase
    end
    // Register contents: restore first, then valid writes
    if (nvm_restore) begin
      n.trim = nvm_trim;
      n.mhi = nvm_margin_dflt ? `OVTL_MHI_DFLT1 : `OVTL_MHI_DFLT0; // R17
      n.vmax = vmax_from_strap ? strap_vmax : nvm_vmax; // R21
    end else if (commit && !bad) begin
      case (q.cmd)
        `OVTL_CMD_TRIM: n.trim = word[6:0]; // R4
        `OVTL_CMD_VMAX: n.vmax = word[11:0]; // R8
        default:        n.mhi = word[10:0]; // R16
      endcase
    end
    // Target re-evaluated every cycle in one update
    if (gt_hi) begin
      n.target = hi_lim; // R6 R9 R11 R20 R23
    end else if (lt_lo) begin
      n.target = lo_lim;
    end else begin
      n.target = raw[12:0];
    end
    // Sticky status, a new event beats the clear
    if (status_clear) begin
      n.warn = 1'b0;
      n.inv = 1'b0;
    end
    if (conv_enable && clamp_act) begin
      n.warn = 1'b1; // R9 R10 R11
    end
    if (commit && bad && !nvm_restore) begin
      n.inv = 1'b1; // R7
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_d <= 1'b1;
      q.sda_d <= 1'b1;
      q.trim <= `OVTL_TRIM_RST;
      q.vmax <= `OVTL_VMAX_RST;
      q.mhi <= `OVTL_MHI_DFLT0;
    end else begin
      q <= n;
    end
  end

  // Slew limiter toward the clamped target
  ovtl_slew_ramp u_ramp (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .target   (q.target),
    .rate     (trans_rate),
    .vout_now (vout_ramped),
    .busy     (ramp_busy)
  );

  // Outputs and host notification
  assign sda_o   = 1'b0;
  assign sda_oe  = q.sda_oe;
  assign alert_o = 1'b0;
  assign alert_oe = q.warn | q.inv; // R7 R10
  assign warn_max_min     = q.warn;
  assign status_byte_nota = q.warn; // R10
  assign status_word_vout = q.warn;
  assign invalid_data     = q.inv;
  assign vout_target      = q.target;
  assign margin_high_default_bit = (q.mhi >= `OVTL_MHI_SPLIT); // R18

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_target_ceiling: assert property ( // R9
    vout_target <= {1'b0, $past(q.vmax)})
    else $error("target above upper limit");
  chk_hw_clamp: assert property ( // R6
    vout_target <= $past(hw_max))
    else $error("target above hardware maximum");
  chk_warn_raise: assert property ( // R10
    (conv_enable && clamp_act) |=> warn_max_min && status_word_vout
    && alert_oe)
    else $error("clamp without warning");
  chk_invalid_flag: assert property ( // R7
    (commit && bad && !nvm_restore) |=> invalid_data ##0 alert_oe)
    else $error("invalid write not flagged");
  chk_limit_guard: assert property ( // R8
    (commit && bad && !nvm_restore) |=> $stable(q.vmax) && $stable(q.trim)
    && $stable(q.mhi))
    else $error("invalid write changed a register");
  chk_trim_sext: assert property ( // R4
    (q.st == OVTL_RACK && scl_fall && q.rd && q.cmd == `OVTL_CMD_TRIM
     && q.bidx == 2'h0) |=> q.txd[15:7] == {9{q.txd[6]}})
    else $error("trim read not sign extended");
  chk_margin_restore: assert property ( // R17
    nvm_restore |=> q.mhi == ($past(nvm_margin_dflt) ? `OVTL_MHI_DFLT1
                                                     : `OVTL_MHI_DFLT0))
    else $error("margin default not restored");
  chk_floor_yields: assert property ( // R12
    ($past(vout_min) > {1'b0, $past(q.vmax)})
    |-> vout_target <= {1'b0, $past(q.vmax)})
    else $error("lower limit overrode upper limit");
endmodule

// *** hdl/ovtl_defines.svh ***
// Behaviour
// R1 - Commands 22h, 24h, 25h use word transfers
// R2 - Trim is signed offset, applied on fly
// R3 - Trim changes slew at transition rate
// R4 - Trim bits 6:0 writable, 15:7 sign copies
// R5 - Host keeps trim within +123/-125 mV
// R6 - Above hardware max: clamp, raise warning
// R7 - Out-of-range writes flagged as invalid data
// R8 - Limit bits 15:12 read zero, 11:0 writable
// R9 - Target above limit warns, moves to limit
// R10 - Warning sets byte, word, vout status bits
// R11 - Limit written below target also warns
// R12 - Upper limit wins over lower limit
// R13 - Host keeps limit codes in recommended range
// R14 - Margin high scales command, plus trim
// R15 - Margin transitions slew at transition rate
// R16 - Margin bits 15:11 read zero, 10:0 writable
// R17 - Restore margin from one default bit
// R18 - Store default bit as code >= 532
// R19 - Margin quantised in eight-code steps
// R20 - Margin target held within upper limit
// R21 - Limit restored from memory or strap
// R22 - All voltage codes are 1.953 mV per bit
// R23 - Any write re-evaluates target in one update
`ifndef OVTL_DEFINES_SVH
`define OVTL_DEFINES_SVH
`define OVTL_CMD_TRIM   8'h22
`define OVTL_CMD_VMAX   8'h24
`define OVTL_CMD_MHI    8'h25
`define OVTL_DEV_ADDR   7'h24
`define OVTL_RD_NONE    16'hffff
`define OVTL_TRIM_RST   7'h00
`define OVTL_VMAX_RST   12'h400
`define OVTL_MHI_DFLT0  11'h210
`define OVTL_MHI_DFLT1  11'h218
`define OVTL_MHI_SPLIT  11'h214
`define OVTL_MHI_LO     11'h20c
`define OVTL_MHI_SAT    11'h23c
`define OVTL_MHI_BASE   11'h1fc
`define OVTL_MHI_MIN    4'h1
`define OVTL_MHI_MAX    4'h8
`define OVTL_MHI_SHIFT  6
`define OVTL_RATE_MIN   8'h05
`define OVTL_CLK_HZ     10000000
`define OVTL_VOUT_LSB_NV 1953125
`define OVTL_RATE_LSB_NV 125000
`define OVTL_ACC_SCALE  16
`define OVTL_ACC_LSB    13'((`OVTL_VOUT_LSB_NV * `OVTL_ACC_SCALE * \
  (`OVTL_CLK_HZ / 1000000)) / `OVTL_RATE_LSB_NV)
`define OVTL_ACC_SAT    13'h1388
`endif

// *** hdl/ovtl_pkg.sv ***
package ovtl_pkg;
  typedef enum logic [2:0] {
    OVTL_IDLE, OVTL_RX, OVTL_RACK, OVTL_TX, OVTL_TACK
  } ovtl_bus_e;

  typedef struct packed {
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic        scl_d;
    logic        sda_d;
    ovtl_bus_e   st;
    logic [3:0]  bitc;
    logic [1:0]  bidx;
    logic [7:0]  sh;
    logic [7:0]  cmd;
    logic [7:0]  lo;
    logic        rd;
    logic        ack;
    logic        txhi;
    logic [15:0] txd;
    logic        sda_oe;
    logic [6:0]  trim;
    logic [11:0] vmax;
    logic [10:0] mhi;
    logic [12:0] target;
    logic        warn;
    logic        inv;
  } ovtl_main_s;

  typedef struct packed {
    logic [12:0] cur;
    logic [12:0] acc;
  } ovtl_ramp_s;
endpackage

// *** hdl/ovtl_slew_ramp.sv ***
`timescale 1ns/1ps
`include "ovtl_defines.svh"
module ovtl_slew_ramp import ovtl_pkg::*; (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Target and rate
  input  wire logic [12:0] target,
  input  wire logic [7:0]  rate,
  // Ramped output
  output logic      [12:0] vout_now,
  output logic             busy
);
  ovtl_ramp_s q;
  ovtl_ramp_s n;
  logic [7:0]  eff;
  logic [13:0] sum;

  // Rate below the slowest setting runs at the slowest
  assign eff = (rate < `OVTL_RATE_MIN) ? `OVTL_RATE_MIN : rate;

  // Accumulate rate, step one code per full LSB
  always_comb begin
    n = q;
    sum = 14'(q.acc) + 14'(eff) * 14'(`OVTL_ACC_SCALE); // No wrap at top rate
    if (q.cur == target) begin
      n.acc = 13'h0;
    end else begin
      if (sum >= 14'(`OVTL_ACC_LSB)) begin
        sum = sum - 14'(`OVTL_ACC_LSB);
        n.cur = (target > q.cur) ? q.cur + 13'h1 : q.cur - 13'h1; // R3 R15
      end
      n.acc = (sum > 14'(`OVTL_ACC_SAT)) ? `OVTL_ACC_SAT : sum[12:0];
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign vout_now = q.cur;
  assign busy     = (q.cur != target);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_ramp_no_step: assert property ( // R3
    vout_now == $past(vout_now) + 13'h1 || vout_now == $past(vout_now)
    || vout_now == $past(vout_now) - 13'h1)
    else $error("ramp moved more than one code");
  chk_ramp_settled: assert property ( // R15
    (!busy && $stable(target)) |=> $stable(vout_now))
    else $error("ramp moved while settled");
endmodule

// *** sim/ovtl_pmbus_host.sv ***
`timescale 1ns/1ps
module ovtl_pmbus_host #(
  parameter logic [6:0] DEV_ADDR = 7'h24
) (
  // Clock
  input  wire logic clk_sys,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl_o,
  output logic      sda_pull
);
  logic nak;

  // Bus idles high, clock still between frames
  initial begin
    scl_o = 1'b1;
    sda_pull = 1'b0;
    nak = 1'b0;
  end

  // Set both lines just after an edge, hold n clocks
  task automatic phase(input logic c, input logic p, input int n);
    scl_o = c;
    sda_pull = p;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Start and stop conditions
  task automatic start();
    phase(1'b0, sda_pull, 2);
    phase(1'b0, 1'b0, 2);
    phase(1'b1, 1'b0, 2);
    phase(1'b1, 1'b1, 2);
  endtask
  task automatic stop();
    phase(1'b0, sda_pull, 2);
    phase(1'b0, 1'b1, 2);
    phase(1'b1, 1'b1, 2);
    phase(1'b1, 1'b0, 4);
  endtask

  // One bit, 800 ns period, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    phase(1'b0, sda_pull, 2);
    phase(1'b0, ~b, 2);
    phase(1'b1, ~b, 2);
    s = sda_line;
    phase(1'b1, ~b, 2);
  endtask

  // Byte MSB first plus ack bit
  task automatic xfer(input logic [7:0] b, input logic ab,
                      output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ab, s);
    nak = nak | (s & ab);
  endtask

  // Word transfers, low byte first
  task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d,
                         output logic n);
    logic [7:0] r;
    nak = 1'b0;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(cmd, 1'b1, r);
    xfer(d[7:0], 1'b1, r);
    xfer(d[15:8], 1'b1, r);
    stop();
    n = nak;
  endtask
  task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d,
                         output logic n);
    logic [7:0] r;
    nak = 1'b0;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(cmd, 1'b1, r);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r);
    xfer(8'hff, 1'b0, d[7:0]);
    n = nak;
    xfer(8'hff, 1'b1, d[15:8]);
    stop();
  endtask
endmodule

// *** sim/ovtl_limits_tb_top.sv ***
`timescale 1ns/1ps
module ovtl_limits_tb_top;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        scl_o, sda_pull, sda_line, sda_o, sda_oe, alert_o, alert_oe;
  logic        margin_high_sel, conv_enable, nvm_restore, nvm_margin_dflt;
  logic        vmax_from_strap, status_clear, ramp_busy;
  logic        margin_high_default_bit, warn_max_min, status_byte_nota;
  logic        status_word_vout, invalid_data, nak;
  logic [12:0] vout_command, vout_min, hw_max, vout_target, vout_ramped;
  logic [11:0] nvm_vmax, strap_vmax;
  logic [7:0]  trans_rate;
  logic [6:0]  nvm_trim;
  logic [15:0] rd;
  int          err_count = 0;
  int          n_tests = 0;
  int          seed = 21917;
  int          m_trim = 0, m_vmax = 1024, m_mhi = 528, m_warn = 0, m_inv = 0;
  int          e_warn, code;
  int          codes[7] = '{523, 524, 531, 532, 571, 572, 2047};

  // Clock and pulled-up data line
  always #50 clk_sys = ~clk_sys;
  assign sda_line = ~(sda_pull | sda_oe);

  // Host model and device
  ovtl_pmbus_host u_host (.clk_sys, .sda_line, .scl_o, .sda_pull);
  ovtl_limits u_dut (.clk_sys, .sys_rst, .scl_i(scl_o), .sda_i(sda_line),
    .sda_o, .sda_oe, .alert_o, .alert_oe, .vout_command, .margin_high_sel,
    .conv_enable, .vout_min, .hw_max, .trans_rate, .nvm_restore,
    .nvm_margin_dflt, .nvm_trim, .nvm_vmax, .vmax_from_strap, .strap_vmax,
    .margin_high_default_bit, .status_clear, .warn_max_min,
    .status_byte_nota, .status_word_vout, .invalid_data, .vout_target,
    .vout_ramped, .ramp_busy);

  // Reference target and warning condition
  function automatic int exp_t();
    int k;
    int c;
    int f;
    int raw;
    k = (m_mhi < 524) ? 1 : (m_mhi < 572) ? (m_mhi - 508) >> 3 : 8;
    raw = vout_command + m_trim
          + (margin_high_sel ? (vout_command * k) >> 6 : 0);
    c = (hw_max < m_vmax) ? hw_max : m_vmax;
    f = (vout_min < c) ? vout_min : c;
    e_warn = conv_enable && (raw > c || raw < f);
    return (raw > c) ? c : (raw < f) ? f : raw;
  endfunction

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  // Compare target and flags with the model
  task automatic settle();
    int t;
    repeat (2) @(posedge clk_sys);
    #1;
    t = exp_t();
    m_warn = m_warn | e_warn;
    chk(vout_target, t);
    chk(warn_max_min, m_warn);
    chk({status_byte_nota, status_word_vout}, {2{m_warn[0]}});
    chk(invalid_data, m_inv);
    chk(alert_oe, m_warn | m_inv);
    chk({sda_o, alert_o}, 16'h0000);
  endtask

  // Register accesses
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d,
                    input logic ok);
    u_host.wr_word(cmd, d, nak);
    chk(nak, 0);
    if (!ok) m_inv = 1;
    else if (cmd == 8'h22) m_trim = $signed(d[6:0]);
    else if (cmd == 8'h24) m_vmax = d[11:0];
    else m_mhi = d[10:0];
    settle();
  endtask
  task automatic rdchk(input logic [7:0] cmd, input logic [15:0] want);
    u_host.rd_word(cmd, rd, nak);
    chk(nak, 0);
    chk(rd, want);
  endtask

  task automatic clear();
    status_clear = 1'b1;
    @(posedge clk_sys);
    #1;
    status_clear = 1'b0;
    m_warn = 0;
    m_inv = 0;
    settle();
  endtask

  // Slewed output: single steps, bounded wait
  task automatic ramp(input int min_cyc);
    int n;
    int d;
    int prev;
    logic bad;
    n = 0;
    bad = 1'b0;
    prev = int'(vout_ramped);
    while (vout_ramped !== vout_target && n < 4000) begin
      @(posedge clk_sys);
      #1;
      d = int'(vout_ramped) - prev;
      bad = bad | (d > 1 || d < -1);
      prev = int'(vout_ramped);
      n++;
    end
    if (n >= 4000) begin
      err_count++;
      $display("wrong value at %0t: ramp did not settle", $time);
      tally_and_finish();
    end
    chk(bad, 0);
    chk(n >= min_cyc, 1);
    chk(ramp_busy, 0);
  endtask

  // Main sequence
  initial begin
    vout_command = 13'h12c;
    vout_min = 13'h000;
    hw_max = 13'h5dc;
    trans_rate = 8'ha0;
    {margin_high_sel, conv_enable, nvm_restore} = 3'b010;
    {nvm_margin_dflt, vmax_from_strap, status_clear} = 3'b000;
    nvm_trim = 7'h00;
    nvm_vmax = 12'h000;
    strap_vmax = 12'h000;
    repeat (3) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    settle();
    ramp(0);
    rdchk(8'h22, 16'h0000);
    rdchk(8'h24, 16'h0400);
    rdchk(8'h25, 16'h0210);
    rdchk(8'h23, 16'hffff);
    wr(8'h22, 16'hfffb, 1);
    rdchk(8'h22, 16'hfffb);
    wr(8'h22, 16'h007b, 0);
    rdchk(8'h22, 16'hfffb);
    trans_rate = 8'h00;
    wr(8'h22, 16'h000a, 1);
    ramp(400);
    trans_rate = 8'ha0;
    clear();
    wr(8'h24, 16'h1100, 0);
    rdchk(8'h24, 16'h0400);
    wr(8'h24, 16'h0180, 1);
    wr(8'h24, 16'h0130, 1);
    clear();
    wr(8'h24, 16'h0180, 1);
    clear();
    hw_max = 13'h131;
    settle();
    hw_max = 13'h5dc;
    vout_min = 13'h186;
    clear();
    conv_enable = 1'b0;
    clear();
    conv_enable = 1'b1;
    vout_min = 13'h000;
    settle();
    wr(8'h24, 16'h028a, 1);
    vout_command = 13'h258;
    margin_high_sel = 1'b1;
    settle();
    ramp(0);
    for (int i = 0; i < 8; i++) begin
      code = (i < 7) ? codes[i] : 500 + ($random(seed) & 127);
      wr(8'h25, code[15:0], 1);
      rdchk(8'h25, code[15:0]);
      chk(margin_high_default_bit, code >= 532);
    end
    wr(8'h25, 16'h0800, 0);
    rdchk(8'h25, code[15:0]);
    for (int i = 0; i < 2; i++) begin
      {nvm_margin_dflt, vmax_from_strap} = i ? 2'b10 : 2'b01;
      nvm_trim = 7'h7d;
      nvm_vmax = 12'h1f4;
      strap_vmax = 12'h258;
      nvm_restore = 1'b1;
      @(posedge clk_sys);
      #1;
      nvm_restore = 1'b0;
      m_mhi = i ? 536 : 528;
      m_trim = -3;
      m_vmax = i ? 500 : 600;
      settle();
      rdchk(8'h25, i ? 16'h0218 : 16'h0210);
      rdchk(8'h24, m_vmax[15:0]);
      rdchk(8'h22, 16'hfffd);
    end
    margin_high_sel = 1'b0;
    for (int i = 0; i < 4; i++) begin
      vout_command = 13'd200 + 13'($random(seed) & 511);
      code = $random(seed) % 63;
      wr(8'h22, code[15:0], 1);
    end
    ramp(0);
    tally_and_finish();
  end
endmodule
